// [adcsm_pkg.sv]
/*
  shared constants for the converter serial interface: code range, conversion
  timing, state encoding and the state record of the interface logic.
  assumes a single 20 MHz system clock.
*/
package adcsm_pkg;

    // ****************************************
    // code format
    // ****************************************
    localparam int CODE_W = 14;
    localparam int SAMPLE_W = 16;
    localparam logic [CODE_W-1:0] CODE_TOP = 14'h3fff;
    localparam logic [CODE_W-1:0] CODE_BOTTOM = 14'h0000;
    localparam int SHIFT_W = CODE_W + 1;
    localparam int LEFT_W = 5;
    localparam logic [LEFT_W-1:0] BITS_PLAIN = 5'h0e;
    localparam logic [LEFT_W-1:0] BITS_WITH_START = 5'h0f;
    localparam logic [LEFT_W-1:0] BITS_LAST = 5'h01;
    localparam logic CS_START_BIT = 1'b0;
    localparam logic CHAIN_START_BIT = 1'b1;
    localparam logic PAD_BIT = 1'b0;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 50;
    localparam int CONV_TIME_NS = 2200;
    localparam int CONV_CYCLES_RAW = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_CYCLES = (CONV_CYCLES_RAW < 1) ? 1 : CONV_CYCLES_RAW;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] CONV_LOAD = CNT_W'(CONV_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
    localparam int SYNC_STAGES = 2;

    // ****************************************
    // state
    // ****************************************
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONVERT = 2'b01,
        ST_READ = 2'b10
    } adcsm_phase_e;

    typedef struct packed {
        adcsm_phase_e phase;
        logic chain_mode;
        logic busy_en;
        logic [CNT_W-1:0] conv_cnt;
        logic [CODE_W-1:0] code;
        logic [SHIFT_W-1:0] shreg;
        logic [LEFT_W-1:0] bits_left;
        logic read_done;
        logic out_en;
        logic powered_down;
        logic converting;
        logic cnv_prev;
        logic sck_prev;
        logic sdi_prev;
    } adcsm_state_s;

endpackage : adcsm_pkg

// [adcsm_sync.sv]
/*
  two-stage level synchroniser for one pin input.
  assumes the input is asynchronous to clock; only the last stage is read.
*/
`timescale 1ns/1ps
module adcsm_sync #(
    parameter int STAGES = 2
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic async_in,
    output logic sync_out
);

    // ****************************************
    // flop chain
    // ****************************************
    logic [STAGES-1:0] chain;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            chain <= '0;
        end else begin
            chain <= {chain[STAGES-2:0], async_in};
        end
    end

    assign sync_out = chain[STAGES-1];

endmodule : adcsm_sync

// [adcsm_serial_if.sv]
/*
  digital side of a 14-bit sampling converter: mode pick at conversion start,
  internally timed conversion, busy start bit, chip-select and chain readout,
  power-down after each conversion.
  assumes all pins (convert start, select/data in, serial clock) are
  asynchronous; they are synchronised here. sample_level is the held analog
  value, already digitised to a signed figure, stable while start rises.
*/
// Overview of operation
// R1 - start rising edge samples select input: high picks chip-select mode, low picks chain
// R2 - select is taken from before the edge, so tying it to start picks chain
// R3 - a single start bit may precede the result, acting as busy flag
// R4 - without busy flag host waits the full conversion time before reading
// R5 - chip-select mode: busy bit enabled if start or select is low at conversion end
// R6 - chain mode: busy bit enabled if serial clock is high at start edge
// R7 - chain mode shifts upstream data from select input through the output
// R8 - block powers down automatically when each conversion ends
// R9 - three-wire uses start as select; four-wire uses select input for readback
// R10 - conversion timed by internal counter, never by serial clock
// R11 - start rising edge begins conversion and releases the output
// R12 - result goes MSB first; chip-select output released after 14th falling edge (15th with busy bit) or start rising
// R13 - codes are straight binary, clamped to bottom and top code
// R14 - mode and busy choice hold until the next start rising edge
`timescale 1ns/1ps
module adcsm_serial_if #(
    parameter int SAMPLE_W = adcsm_pkg::SAMPLE_W
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic convert_start_in,
    input wire logic serial_in_select,
    input wire logic serial_clock_in,
    input wire logic signed [SAMPLE_W-1:0] sample_level,
    output logic serial_result_out,
    output logic serial_result_oe,
    output logic converting,
    output logic powered_down
);

    // ****************************************
    // pin synchronisers
    // ****************************************
    // two flops a pin; the edge stage adds one more cycle of lag
    logic cnv_s;
    logic sdi_s;
    logic sck_s;

    adcsm_sync #(.STAGES(adcsm_pkg::SYNC_STAGES)) u_sync_cnv (
        .clock(clock),
        .sys_rst(sys_rst),
        .async_in(convert_start_in),
        .sync_out(cnv_s)
    );

    adcsm_sync #(.STAGES(adcsm_pkg::SYNC_STAGES)) u_sync_sdi (
        .clock(clock),
        .sys_rst(sys_rst),
        .async_in(serial_in_select),
        .sync_out(sdi_s)
    );

    adcsm_sync #(.STAGES(adcsm_pkg::SYNC_STAGES)) u_sync_sck (
        .clock(clock),
        .sys_rst(sys_rst),
        .async_in(serial_clock_in),
        .sync_out(sck_s)
    );

    // ****************************************
    // code clamp
    // ****************************************
    // out-of-range samples saturate instead of wrapping
    function automatic logic [adcsm_pkg::CODE_W-1:0] clamp_code(input logic signed [SAMPLE_W-1:0] v);
        logic signed [SAMPLE_W:0] top;
        top = (SAMPLE_W + 1)'(adcsm_pkg::CODE_TOP);
        if (v < 0) begin
            clamp_code = adcsm_pkg::CODE_BOTTOM; // R13
        end else if ((SAMPLE_W + 1)'(v) > top) begin
            clamp_code = adcsm_pkg::CODE_TOP; // R13
        end else begin
            clamp_code = v[adcsm_pkg::CODE_W-1:0];
        end
    endfunction : clamp_code

    // ****************************************
    // state
    // ****************************************
    adcsm_pkg::adcsm_state_s q;
    adcsm_pkg::adcsm_state_s next_q;

    logic cnv_rise;
    logic sck_fall;
    logic cs_select;
    logic busy_now;
    logic conv_end;

    // ****************************************
    // edge detect and select
    // ****************************************
    // prev flops reset low, matching the idle pin level, so no false edge
    assign cnv_rise = cnv_s & ~q.cnv_prev;
    assign sck_fall = ~sck_s & q.sck_prev;
    // one low line selects: start in three-wire, select input in four-wire
    assign cs_select = ~(cnv_s & sdi_s); // R9
    assign conv_end = q.conv_cnt == adcsm_pkg::CNT_ZERO; // R10

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        busy_now = 1'b0;
        next_q = q;
        next_q.cnv_prev = cnv_s;
        next_q.sck_prev = sck_s;
        next_q.sdi_prev = sdi_s;
        if (cnv_rise) begin
            next_q.phase = adcsm_pkg::ST_CONVERT; // R11
            // previous-cycle select gives the hold window; tied pins read low
            next_q.chain_mode = ~q.sdi_prev; // R1 R2 R14
            next_q.busy_en = ~q.sdi_prev & sck_s; // R6
            next_q.conv_cnt = adcsm_pkg::CONV_LOAD; // R10
            next_q.code = clamp_code(sample_level); // R13
            next_q.out_en = 1'b0; // R11
            next_q.read_done = 1'b0;
            next_q.powered_down = 1'b0;
            next_q.converting = 1'b1;
        end else begin
            unique case (q.phase)
                adcsm_pkg::ST_IDLE: begin
                    next_q.out_en = 1'b0;
                end
                adcsm_pkg::ST_CONVERT: begin
                    // counts system clocks only; serial clock plays no part
                    if (conv_end) begin // R10
                        next_q.phase = adcsm_pkg::ST_READ;
                        next_q.powered_down = 1'b1; // R8
                        next_q.converting = 1'b0;
                        if (q.chain_mode) begin
                            busy_now = q.busy_en; // R6
                        end else begin
                            busy_now = ~cnv_s | ~sdi_s; // R5
                        end
                        next_q.busy_en = busy_now; // R14
                        if (busy_now) begin
                            next_q.bits_left = adcsm_pkg::BITS_WITH_START; // R3
                            if (q.chain_mode) begin
                                // chain start bit waits for start low like the data behind it
                                next_q.shreg = {adcsm_pkg::CHAIN_START_BIT, q.code}; // R3
                                next_q.out_en = ~cnv_s; // R3
                            end else begin
                                // driving low at once is the busy edge a pulled-up line shows
                                next_q.shreg = {adcsm_pkg::CS_START_BIT, q.code}; // R3 R5
                                next_q.out_en = 1'b1; // R3
                            end
                        end else begin
                            next_q.shreg = {q.code, adcsm_pkg::PAD_BIT}; // R12
                            next_q.bits_left = adcsm_pkg::BITS_PLAIN; // R12
                            next_q.out_en = 1'b0;
                        end
                    end else begin
                        next_q.conv_cnt = q.conv_cnt - adcsm_pkg::CNT_ONE;
                    end
                end
                adcsm_pkg::ST_READ: begin
                    if (q.chain_mode) begin
                        // chain runs unbounded; upstream data follows ours
                        next_q.out_en = ~cnv_s;
                        if (sck_fall && !cnv_s) begin
                            next_q.shreg = {q.shreg[adcsm_pkg::SHIFT_W-2:0], sdi_s}; // R7
                        end
                    end else if (!cs_select) begin
                        // deselect ends a read only once it has begun; idle wait keeps it armed
                        next_q.out_en = 1'b0; // R12
                        next_q.read_done = q.read_done | q.out_en; // R12
                    end else if (!q.read_done) begin
                        next_q.out_en = 1'b1; // R9
                        if (sck_fall && q.out_en) begin
                            next_q.shreg = {q.shreg[adcsm_pkg::SHIFT_W-2:0], adcsm_pkg::PAD_BIT}; // R12
                            next_q.bits_left = q.bits_left - adcsm_pkg::BITS_LAST;
                            if (q.bits_left == adcsm_pkg::BITS_LAST) begin
                                next_q.out_en = 1'b0; // R12
                                next_q.read_done = 1'b1;
                            end
                        end
                    end
                end
                default: begin
                    next_q.phase = adcsm_pkg::ST_IDLE;
                    next_q.out_en = 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // registers
    // ****************************************
    // reset leaves the output released and the core powered down
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '{phase: adcsm_pkg::ST_IDLE, powered_down: 1'b1, default: '0};
        end else begin
            q <= next_q;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // every output is a state flop, so pins never glitch on decode
    assign serial_result_out = q.shreg[adcsm_pkg::SHIFT_W-1];
    assign serial_result_oe = q.out_en;
    assign converting = q.converting;
    assign powered_down = q.powered_down;

endmodule : adcsm_serial_if

// [adcsm_monitor.sv]
/* pin checker for the converter serial interface.
   sees only the top ports; bound below */
`timescale 1ns/1ps
module adcsm_monitor #(
    parameter int SAMPLE_W = 16
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic convert_start_in,
    input wire logic serial_in_select,
    input wire logic serial_clock_in,
    input wire logic signed [SAMPLE_W-1:0] sample_level,
    input wire logic serial_result_out,
    input wire logic serial_result_oe,
    input wire logic converting,
    input wire logic powered_down
);
    // ****
    // pin relations
    // ****
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    a_conv_len: assert property ($rose(converting) |-> ##43 converting ##1 !converting)
        else $error("conversion length wrong");
    a_rise_conv: assert property ($rose(converting) |-> $past(convert_start_in, 2))
        else $error("conversion without start");
    a_start_hiz: assert property ($rose(convert_start_in) |-> ##[1:5] (converting && !serial_result_oe))
        else $error("start did not release output");
    a_conv_hiz: assert property (converting |-> !serial_result_oe)
        else $error("output driven in conversion");
    a_end_pd: assert property ($fell(converting) |-> powered_down)
        else $error("no power down at end");
    // pins pass two flops and an edge stage, so five cycles covers the lag
    a_deselect: assert property (convert_start_in && serial_in_select [*5] |-> !serial_result_oe)
        else $error("output on while deselected");
    a_out_stable: assert property ($stable(serial_clock_in) [*6] ##1 (serial_result_oe && $past(serial_result_oe))
        |-> $stable(serial_result_out))
        else $error("output moved without clock");
    a_oe_cause: assert property ($rose(serial_result_oe) |-> !$past(convert_start_in && serial_in_select, 3))
        else $error("output on without select");
endmodule : adcsm_monitor

bind adcsm_serial_if adcsm_monitor #(.SAMPLE_W(SAMPLE_W)) u_adcsm_monitor (.clock(clock), .sys_rst(sys_rst),
    .convert_start_in(convert_start_in), .serial_in_select(serial_in_select), .serial_clock_in(serial_clock_in),
    .sample_level(sample_level), .serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe),
    .converting(converting), .powered_down(powered_down));

// [adcsm_host.sv]
/* host model: makes the serial clock and captures result bits.
   assumes the bench drives start and select; line has a pull-up */
`timescale 1ns/1ps
module adcsm_host (
    input wire logic clock,
    input wire logic serial_result_out,
    input wire logic serial_result_oe,
    output logic serial_clock_in
);
    // ****
    // serial read
    // ****
    logic line;
    // released line floats to the pull-up level
    assign line = serial_result_oe ? serial_result_out : 1'b1;
    initial serial_clock_in = 1'b0;
    task automatic park(input logic k);
        serial_clock_in = k;
    endtask : park
    // 400 ns per bit; clock idles low between frames
    task automatic read(input int n, output logic [31:0] v);
        v = 32'h0;
        repeat (n) begin
            repeat (4) @(negedge clock);
            serial_clock_in = 1'b1;
            repeat (4) @(negedge clock);
            v = {v[30:0], line};
            serial_clock_in = 1'b0;
        end
    endtask : read
endmodule : adcsm_host

// [tb_top.sv]
/* bench for the converter serial interface: cs, busy and chain reads.
   assumes the host model owns the serial clock */
`timescale 1ns/1ps
module tb_top;
    logic clock, sys_rst, start, sel, sclk, out, oe, conv, pd;
    logic signed [15:0] lvl;
    logic [31:0] v;
    int fail_count = 0;
    int cmp_count = 0;
    adcsm_serial_if u_adcsm_serial_if (.clock(clock), .sys_rst(sys_rst), .convert_start_in(start),
        .serial_in_select(sel), .serial_clock_in(sclk), .sample_level(lvl), .serial_result_out(out),
        .serial_result_oe(oe), .converting(conv), .powered_down(pd));
    adcsm_host u_adcsm_host (.clock(clock), .serial_result_out(out), .serial_result_oe(oe),
        .serial_clock_in(sclk));
    // ****
    // tasks
    // ****
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask : cyc
    task automatic end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    // select follows start at the edge, as if tied; its prior level picks the mode
    task automatic go(input logic cs, input logic k, input logic [15:0] l);
        start = 1'b0;
        sel = cs;
        lvl = l;
        u_adcsm_host.park(k);
        cyc(4);
        start = 1'b1;
        sel = 1'b1;
        cyc(5);
        chk("conv", conv, 1);
        chk("oe", oe, 0);
        chk("pd conv", pd, 0);
        u_adcsm_host.park(1'b0);
    endtask : go
    task automatic t_cs(input logic [15:0] l, input logic [13:0] c);
        go(1'b1, 1'b0, l);
        cyc(50);
        chk("pd", pd, 1);
        chk("conv end", conv, 0);
        chk("idle oe", oe, 0);
        start = 1'b0;
        cyc(5);
        chk("oe on", oe, 1);
        u_adcsm_host.read(14, v);
        chk("code", v, {18'h0, c});
        cyc(5);
        chk("oe off", oe, 0);
        $display("cs read done");
    endtask : t_cs
    task automatic t_busy;
        int i;
        go(1'b1, 1'b0, 16'h2a5c);
        sel = 1'b0;
        for (i = 0; i < 60 && oe !== 1'b1; i++)
            cyc(1);
        chk("busy conv", conv, 0);
        chk("busy bit", out, 0);
        u_adcsm_host.read(15, v);
        chk("busy code", v, 32'h2a5c);
        cyc(5);
        chk("oe off", oe, 0);
        sel = 1'b1;
        $display("busy read done");
    endtask : t_busy
    task automatic t_chain(input logic k);
        go(1'b0, k, 16'h1357);
        cyc(50);
        start = 1'b0;
        cyc(5);
        chk("chain oe", oe, 1);
        u_adcsm_host.read(18, v);
        chk("chain data", v, k ? {14'h0, 1'b1, 14'h1357, 3'h7} : {14'h0, 14'h1357, 1'b0, 3'h7});
        $display("chain read done");
    endtask : t_chain
    // ****
    // run
    // ****
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    initial begin
        sys_rst = 1'b1;
        start = 1'b0;
        sel = 1'b0;
        lvl = 16'h0000;
        cyc(16);
        sys_rst = 1'b0;
        chk("pd rst", pd, 1);
        t_chain(1'b0);
        t_chain(1'b1);
        t_cs(16'h1234, 14'h1234);
        t_cs(16'h7fff, 14'h3fff);
        t_cs(16'hfffd, 14'h0000);
        t_busy;
        end_of_test;
    end
    // run needs about 60 us
    initial begin
        #200000;
        fail_count++;
        end_of_test;
    end
endmodule : tb_top
